// ### hdl/asri_map.vh
// register map, field positions and timing constants of the serial register interface
`ifndef ASRI_MAP_VH
`define ASRI_MAP_VH
`define ASRI_ADDR_PART_IDENT    7'h00
`define ASRI_ADDR_REVISION      7'h01
`define ASRI_ADDR_X_LOW         7'h02
`define ASRI_ADDR_X_HIGH        7'h03
`define ASRI_ADDR_Y_LOW         7'h04
`define ASRI_ADDR_Y_HIGH        7'h05
`define ASRI_ADDR_Z_LOW         7'h06
`define ASRI_ADDR_Z_HIGH        7'h07
`define ASRI_ADDR_TEMPERATURE   7'h08
`define ASRI_ADDR_CONDITION     7'h09
`define ASRI_ADDR_COMMAND       7'h0a
`define ASRI_ADDR_SETUP         7'h15
`define ASRI_ADDR_SCRATCH_ONE   7'h12
`define ASRI_ADDR_SCRATCH_TWO   7'h13
`define ASRI_ADDR_LAST          7'h15
// command_bits fields
`define ASRI_CMD_INT_CLEAR      6
`define ASRI_CMD_PATH_CHECK     3
`define ASRI_CMD_MEMS_CHECK     2
`define ASRI_CMD_REINIT         1
`define ASRI_CMD_SLEEP          0
// condition_flags fields
`define ASRI_ST_SELF_PASS       7
`define ASRI_ST_ALERT           4
`define ASRI_ST_LOW_HELD        3
`define ASRI_ST_HIGH_HELD       2
`define ASRI_ST_LOW_LIVE        1
`define ASRI_ST_HIGH_LIVE       0
// setup register (0x15) fields
`define ASRI_SET_FOUR_WIRE      7
`define ASRI_SET_HOLD_DIS       6
// reset values (nonvolatile defaults)
`define ASRI_RST_SETUP          8'h00
`define ASRI_RST_COMMAND        8'h00
`define ASRI_PART_CODE          3'h5 // arbitrary value
`define ASRI_REV_CODE           8'h11 // arbitrary value
// timing
`define ASRI_CLK_MHZ            100
`define ASRI_MS_US              1000
`define ASRI_MS_CYCLES          (`ASRI_MS_US * `ASRI_CLK_MHZ)
`define ASRI_SELF_CHECK_CYCLES  16'h0100
// one millisecond of settling after wake-up
`define ASRI_WAKE_CYCLES        17'h186a0
`endif

// ### hdl/asri_sync.v
// two-flop synchroniser for the serial pins
module asri_sync (
	// clock and reset
	input  wire clock_in,
	input  wire rst_in,
	// asynchronous level and its synchronised copy
	input  wire async_in,
	output reg  sync_out
);
	reg meta_r;

	// first flop feeds only the second one
	always @(posedge clock_in) begin
		if (rst_in) begin
			meta_r   <= 1'b1;
			sync_out <= 1'b1;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule

// ### hdl/asri_alert.v
// alert-phase duration countdown
`include "asri_map.vh"
module asri_alert (
	// clock and reset
	input  wire       clock_in,
	input  wire       rst_in,
	// image durations and events
	input  wire [7:0] low_g_image_in,
	input  wire [7:0] high_g_image_in,
	input  wire       alert_mode_in,
	input  wire       any_motion_in,
	input  wire       threshold_int_in,
	// state
	output reg        alert_out,
	output reg  [7:0] low_g_duration_out,
	output reg  [7:0] high_g_duration_out
);
	reg [16:0] ms_cnt_r;
	wire       ms_tick;

	assign ms_tick = (ms_cnt_r == `ASRI_MS_CYCLES - 1);

	// free millisecond prescaler
	always @(posedge clock_in) begin
		if (rst_in || ms_tick) begin
			ms_cnt_r <= 17'h00000;
		end else begin
			ms_cnt_r <= ms_cnt_r + 17'h00001;
		end
	end

	always @(posedge clock_in) begin
		if (rst_in) begin
			alert_out           <= 1'b0;
			low_g_duration_out  <= 8'h00;
			high_g_duration_out <= 8'h00;
		end else if (alert_out) begin
			if (threshold_int_in || (low_g_duration_out == 8'h00 &&
			    high_g_duration_out == 8'h00)) begin
				alert_out           <= 1'b0;
				low_g_duration_out  <= low_g_image_in;
				high_g_duration_out <= high_g_image_in;
			end else if (ms_tick) begin
				if (low_g_duration_out != 8'h00)
					low_g_duration_out <= low_g_duration_out - 8'h01;
				if (high_g_duration_out != 8'h00)
					high_g_duration_out <= high_g_duration_out - 8'h01;
			end
		end else begin
			low_g_duration_out  <= low_g_image_in;
			high_g_duration_out <= high_g_image_in;
			if (alert_mode_in && any_motion_in)
				alert_out <= 1'b1;
		end
	end
endmodule

// ### hdl/asri_core.v
// serial register interface of a three-axis accelerometer
// How it works
// - path-check bit forces zero acceleration into the converter path.
// - reinitialise bit reloads all registers like power-on, never into sleep.
// - reinitialise may change the four-wire select; host rewrites it.
// - sleep bit stops updates but keeps control and image registers.
// - after wake, data settles in 1 ms before samples update.
// - MEMS self-check runs, clears its bit, loads pass flag with the check result.
// - alert mode plus any-motion sets alert; durations count down per ms.
// - alert ends on threshold interrupt or zero durations; durations reload.
// - held flags stay until cleared; live flags follow the criteria.
// - temperature is 8 bits, 0.5 degC per count, zero is -30 degC.
// - axis is 10-bit two's complement split over low and high byte.
// - high byte frozen after low byte read unless hold disable set.
// - new-data flag sets on update, clears on reading either byte.
// - part code in bits 2-0 of 0x00, revision nibbles in 0x01.
// - transfer: direction bit, seven address bits, data bytes, msb first.
// - reads auto-increment while chip select stays low.
// - only 0x00-0x15 reachable; otherwise the data output is released.
// - four-wire samples on rising edge and drives on falling edge.
// - three-wire is default; four-wire selected by setup bit.
// - writing interrupt-clear drops the interrupt and latched state.
// - three-wire read has one turnaround clock before data.
`include "asri_map.vh"
module asri_core (
	// clock and reset
	input  wire       clock_in,
	input  wire       rst_in,
	// serial pins
	input  wire       sck_in,
	input  wire       csb_n_in,
	input  wire       sdi_in,
	output reg        sdi_out,
	output reg        sdi_oe_out,
	output reg        sdo_out,
	output reg        sdo_oe_out,
	// sensing path
	input  wire [9:0] acc_x_in,
	input  wire [9:0] acc_y_in,
	input  wire [9:0] acc_z_in,
	input  wire       acc_valid_in,
	input  wire [7:0] temp_in,
	input  wire       low_g_in,
	input  wire       high_g_in,
	input  wire       any_motion_in,
	input  wire       self_check_ok_in,
	input  wire [7:0] low_g_image_in,
	input  wire [7:0] high_g_image_in,
	input  wire       alert_mode_in,
	// control outputs
	output wire       zero_acc_out,
	output wire       mems_force_out,
	output wire       sleep_out,
	output reg        int_out,
	output wire       alert_out,
	output wire [7:0] low_g_duration_out,
	output wire [7:0] high_g_duration_out
);
	localparam ST_CMD  = 2'h0;
	localparam ST_TURN = 2'h1;
	localparam ST_DATA = 2'h2;
	localparam ST_SKIP = 2'h3;

	wire sck_s;
	wire csb_s;
	wire sdi_s;
	reg  sck_d_r;
	reg  [1:0] state_r;
	reg  [2:0] bit_r;
	reg  [7:0] shift_r;
	reg  [7:0] tx_r;
	reg  [6:0] addr_r;
	reg  read_r;
	reg  [7:0] setup_r;
	reg  [7:0] cmd_r;
	reg  [7:0] scratch1_r;
	reg  [7:0] scratch2_r;
	reg  [9:0] ax_r [0:2];
	reg  [7:0] hi_r [0:2];
	reg  [2:0] hold_r;
	reg  [2:0] new_r;
	reg  [7:0] temp_r;
	reg  pass_r;
	reg  low_held_r;
	reg  high_held_r;
	reg  [15:0] st_cnt_r;
	reg  [7:0] rd_data;
	reg  reinit_r;
	reg  rise_d_r;
	reg  [16:0] wake_cnt_r;
	integer i;

	wire rise      = sck_s & ~sck_d_r;
	wire fall      = ~sck_s & sck_d_r;
	wire active    = ~csb_s;
	wire four_wire = setup_r[`ASRI_SET_FOUR_WIRE];
	// four-wire drives on falling edge; three-wire on rising
	// three-wire waits one clock so address and bit count have settled
	wire drive_edge = four_wire ? fall : rise_d_r;

	function in_range;
		input [6:0] a;
		begin
			in_range = (a <= `ASRI_ADDR_LAST);
		end
	endfunction

	// axis index of a data address, 3 when not an axis byte
	function [1:0] axis_of;
		input [6:0] a;
		begin
			if (a >= `ASRI_ADDR_X_LOW && a <= `ASRI_ADDR_Z_HIGH)
				axis_of = a[2:1] - 2'h1;
			else
				axis_of = 2'h3;
		end
	endfunction

	asri_sync u_sck (.clock_in(clock_in), .rst_in(rst_in), .async_in(sck_in),
		.sync_out(sck_s));
	asri_sync u_csb (.clock_in(clock_in), .rst_in(rst_in), .async_in(csb_n_in),
		.sync_out(csb_s));
	asri_sync u_sdi (.clock_in(clock_in), .rst_in(rst_in), .async_in(sdi_in),
		.sync_out(sdi_s));

	asri_alert u_alert (
		.clock_in            (clock_in),
		.rst_in              (rst_in | reinit_r),
		.low_g_image_in      (low_g_image_in),
		.high_g_image_in     (high_g_image_in),
		.alert_mode_in       (alert_mode_in),
		.any_motion_in       (any_motion_in),
		.threshold_int_in    (low_g_in | high_g_in),
		.alert_out           (alert_out),
		.low_g_duration_out  (low_g_duration_out),
		.high_g_duration_out (high_g_duration_out)
	);

	assign zero_acc_out   = cmd_r[`ASRI_CMD_PATH_CHECK];
	assign mems_force_out = cmd_r[`ASRI_CMD_MEMS_CHECK];
	assign sleep_out      = cmd_r[`ASRI_CMD_SLEEP];

	// read multiplexer
	always @* begin
		rd_data = 8'h00;
		case (addr_r)
			`ASRI_ADDR_PART_IDENT:  rd_data = {5'h00, `ASRI_PART_CODE};
			`ASRI_ADDR_REVISION:    rd_data = `ASRI_REV_CODE;
			// low bits in 7-6, new-data flag in bit 0
			`ASRI_ADDR_X_LOW:       rd_data = {ax_r[0][1:0], 5'h00, new_r[0]};
			`ASRI_ADDR_Y_LOW:       rd_data = {ax_r[1][1:0], 5'h00, new_r[1]};
			`ASRI_ADDR_Z_LOW:       rd_data = {ax_r[2][1:0], 5'h00, new_r[2]};
			`ASRI_ADDR_X_HIGH:      rd_data = hi_r[0];
			`ASRI_ADDR_Y_HIGH:      rd_data = hi_r[1];
			`ASRI_ADDR_Z_HIGH:      rd_data = hi_r[2];
			// raw code, 0.5 degC steps from -30 degC
			`ASRI_ADDR_TEMPERATURE: rd_data = temp_r;
			`ASRI_ADDR_CONDITION:   rd_data = {pass_r, 2'h0, alert_out, low_held_r,
				high_held_r, low_g_in, high_g_in};
			`ASRI_ADDR_COMMAND:     rd_data = cmd_r;
			`ASRI_ADDR_SCRATCH_ONE: rd_data = scratch1_r;
			`ASRI_ADDR_SCRATCH_TWO: rd_data = scratch2_r;
			`ASRI_ADDR_SETUP:       rd_data = setup_r;
			default:                rd_data = 8'h00;
		endcase
	end

	// serial engine and register file
	always @(posedge clock_in) begin
		sck_d_r <= sck_s;
		// reinitialise acts as a reset of the block
		if (rst_in || reinit_r) begin
			state_r    <= ST_CMD;
			bit_r      <= 3'h0;
			shift_r    <= 8'h00;
			tx_r       <= 8'h00;
			addr_r     <= 7'h00;
			read_r     <= 1'b0;
			// setup reloads, possibly losing four-wire mode
			setup_r    <= `ASRI_RST_SETUP;
			// comes up awake, sleep bit cleared
			cmd_r      <= `ASRI_RST_COMMAND;
			scratch1_r <= 8'h00;
			scratch2_r <= 8'h00;
			hold_r     <= 3'h0;
			new_r      <= 3'h0;
			temp_r     <= 8'h00;
			pass_r     <= 1'b0;
			low_held_r <= 1'b0;
			high_held_r <= 1'b0;
			st_cnt_r   <= 16'h0000;
			int_out    <= 1'b0;
			sdi_out    <= 1'b0;
			sdi_oe_out <= 1'b0;
			sdo_out    <= 1'b0;
			sdo_oe_out <= 1'b0;
			reinit_r   <= 1'b0;
			sck_d_r    <= 1'b1;
			rise_d_r   <= 1'b0;
			wake_cnt_r <= 17'h00000;
			for (i = 0; i < 3; i = i + 1) begin
				ax_r[i] <= 10'h000;
				hi_r[i] <= 8'h00;
			end
		end else begin
			// held flags set on criteria, live ones are direct
			if (low_g_in)
				low_held_r <= 1'b1;
			if (high_g_in)
				high_held_r <= 1'b1;
			if (low_g_in | high_g_in)
				int_out <= 1'b1;
			rise_d_r <= rise;
			// samples settle for 1 ms after wake-up
			if (cmd_r[`ASRI_CMD_SLEEP])
				wake_cnt_r <= `ASRI_WAKE_CYCLES;
			else if (wake_cnt_r != 17'h00000)
				wake_cnt_r <= wake_cnt_r - 17'h00001;
			if (acc_valid_in && !cmd_r[`ASRI_CMD_SLEEP] && wake_cnt_r == 17'h00000) begin
				temp_r <= temp_in;
				for (i = 0; i < 3; i = i + 1) begin
					ax_r[i] <= acc_x_in;
					// hold high byte until it is read
					if (!hold_r[i] || setup_r[`ASRI_SET_HOLD_DIS])
						hi_r[i] <= (i == 0) ? acc_x_in[9:2] :
							(i == 1) ? acc_y_in[9:2] : acc_z_in[9:2];
				end
				ax_r[1] <= acc_y_in;
				ax_r[2] <= acc_z_in;
				new_r  <= 3'h7;
			end
			// self-check runs for a fixed time then clears its bit
			if (cmd_r[`ASRI_CMD_MEMS_CHECK]) begin
				st_cnt_r <= st_cnt_r + 16'h0001;
				if (st_cnt_r == `ASRI_SELF_CHECK_CYCLES) begin
					cmd_r[`ASRI_CMD_MEMS_CHECK] <= 1'b0;
					pass_r   <= self_check_ok_in;
					st_cnt_r <= 16'h0000;
				end
			end
			if (!active) begin
				state_r    <= ST_CMD;
				bit_r      <= 3'h0;
				sdi_oe_out <= 1'b0;
				sdo_oe_out <= 1'b0;
			end else if (rise) begin
				shift_r <= {shift_r[6:0], sdi_s};
				bit_r   <= bit_r + 3'h1;
				case (state_r)
					// direction bit then seven address bits
					ST_CMD: if (bit_r == 3'h7) begin
						read_r  <= shift_r[6];
						addr_r  <= {shift_r[5:0], sdi_s};
						// three-wire read gets a turnaround clock
						state_r <= (shift_r[6] && !four_wire) ? ST_TURN :
							(in_range({shift_r[5:0], sdi_s}) ? ST_DATA : ST_SKIP);
						tx_r    <= 8'h00;
					end
					ST_TURN: begin
						bit_r   <= 3'h0;
						state_r <= in_range(addr_r) ? ST_DATA : ST_SKIP;
					end
					ST_DATA, ST_SKIP: if (bit_r == 3'h7) begin
						// write lands after the full byte
						if (!read_r && state_r == ST_DATA) begin
							case (addr_r)
								`ASRI_ADDR_COMMAND: begin
									cmd_r <= {shift_r[6:0], sdi_s} &
										8'h0f & ~8'h02;
									reinit_r <= shift_r[0];
									if (shift_r[5]) begin
										int_out     <= low_g_in | high_g_in;
										low_held_r  <= low_g_in;
										high_held_r <= high_g_in;
									end
								end
								`ASRI_ADDR_SETUP:       setup_r <= {shift_r[6:0], sdi_s};
								`ASRI_ADDR_SCRATCH_ONE: scratch1_r <= {shift_r[6:0], sdi_s};
								`ASRI_ADDR_SCRATCH_TWO: scratch2_r <= {shift_r[6:0], sdi_s};
								default: ;
							endcase
						end
						if (read_r && axis_of(addr_r) != 2'h3) begin
							// reading either byte clears the flag; set wins
							if (!acc_valid_in)
								new_r[axis_of(addr_r)] <= 1'b0;
							hold_r[axis_of(addr_r)] <= ~addr_r[0];
						end
						// next address while chip select low
						addr_r  <= addr_r + 7'h01;
						state_r <= in_range(addr_r + 7'h01) ? ST_DATA : ST_SKIP;
					end
					default: state_r <= ST_CMD;
				endcase
			end
			// output shifting on the driving edge
			if (active && drive_edge && read_r &&
			    (state_r == ST_DATA || state_r == ST_SKIP) &&
			    !(rise && state_r == ST_CMD)) begin
				if (bit_r == 3'h0)
					tx_r <= {rd_data[6:0], 1'b0};
				else
					tx_r <= {tx_r[6:0], 1'b0};
				// release the line outside the window
				sdo_out    <= (bit_r == 3'h0) ? rd_data[7] : tx_r[7];
				sdi_out    <= (bit_r == 3'h0) ? rd_data[7] : tx_r[7];
				sdo_oe_out <= four_wire & (state_r == ST_DATA);
				sdi_oe_out <= ~four_wire & (state_r == ST_DATA);
			end
		end
	end
endmodule

// ### tb/asri_core_chk.sv
// concurrent checks on the serial register interface ports
module asri_chk (
	// clock and reset
	input logic       clock_in,
	input logic       rst_in,
	// serial side
	input logic       csb_n_in,
	input logic       sdi_oe_out,
	input logic       sdo_oe_out,
	// sensing side
	input logic       alert_mode_in,
	input logic       any_motion_in,
	input logic       low_g_in,
	input logic       high_g_in,
	input logic [7:0] low_g_image_in,
	input logic [7:0] high_g_image_in,
	// control outputs
	input logic       zero_acc_out,
	input logic       mems_force_out,
	input logic       sleep_out,
	input logic       alert_out,
	input logic [7:0] low_g_duration_out,
	input logic [7:0] high_g_duration_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);
	// pins and command bits while deselected, one data output at a time; five cycles cover the synchroniser
	a_idle_release: assert property (csb_n_in [*5] |-> !sdi_oe_out && !sdo_oe_out)
		else $error("data pin driven while deselected");
	a_one_wire: assert property (!(sdi_oe_out && sdo_oe_out))
		else $error("both data outputs enabled");
	a_write_framed: assert property (csb_n_in [*5] |-> $stable(sleep_out) && $stable(zero_acc_out))
		else $error("command bit moved outside a transfer");
	// self check lasts its fixed span then clears itself
	a_self_span: assert property ($rose(mems_force_out) |-> ##250 mems_force_out ##[1:12] !mems_force_out)
		else $error("self check span wrong");
	// alert phase entry, exit and duration handling
	a_alert_set: assert property (alert_mode_in && any_motion_in && !low_g_in && !high_g_in
		&& |low_g_image_in |-> ##[1:3] alert_out)
		else $error("alert not entered");
	a_alert_end: assert property (alert_out && high_g_in |-> ##[1:3] !alert_out)
		else $error("alert not left on threshold");
	a_dur_reload: assert property ($fell(alert_out) |-> ##[0:2] (low_g_duration_out == low_g_image_in
		&& high_g_duration_out == high_g_image_in))
		else $error("durations not restored");
	a_dur_down: assert property (alert_out && $past(alert_out) |->
		low_g_duration_out <= $past(low_g_duration_out))
		else $error("duration rose during alert");
	cover property ($rose(sdi_oe_out));
	cover property ($rose(sdo_oe_out));
	cover property ($fell(alert_out));
endmodule
bind asri_core asri_chk i_asri_chk (.*);

// ### tb/asri_host.sv
// host model: serial master in mode 3, clock idling high
module asri_host (
	// clock
	input  logic       clock_in,
	// serial pins
	input  logic       line_in,
	input  logic       dev_oe_in,
	output logic       sck_out,
	output logic       csb_n_out,
	output logic       mosi_out,
	output logic       mosi_oe_out,
	// read byte with device enable, for the monitor
	output logic [8:0] rd_out,
	output logic       rd_vld_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle: deselected, clock high, line released
	initial begin
		sck_out = 1'b1;
		csb_n_out = 1'b1;
		mosi_out = 1'b0;
		mosi_oe_out = 1'b0;
		rd_out = 9'h000;
		rd_vld_out = 1'b0;
	end
	task hc(input int n);
		repeat (n) @(posedge clock_in);
	endtask
	// data changes with the falling clock, taken just before the rise
	task bitx(input logic w, input logic oe, output logic r);
		sck_out <= 1'b0;
		mosi_out <= w;
		mosi_oe_out <= oe;
		hc(8);
		r = line_in;
		sck_out <= 1'b1;
		hc(8);
	endtask
	// whole transfer; nb below 8 cuts a write byte short on purpose
	task xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd, input int n,
		input int nb, input logic four);
		logic [7:0] c;
		logic [8:0] v;
		c = {rd, a};
		hc(8);
		csb_n_out <= 1'b0;
		hc(8);
		for (int i = 7; i >= 0; i--)
			bitx(c[i], 1'b1, v[0]);
		for (int i = 7; !rd && i > 7 - nb; i--)
			bitx(wd[i], 1'b1, v[0]);
		if (rd && !four)
			bitx(1'b0, 1'b0, v[0]);
		for (int k = 0; rd && k < n; k++) begin
			for (int i = 7; i >= 0; i--)
				bitx(1'b1, four, v[i]);
			v[8] = dev_oe_in;
			rd_out <= v;
			rd_vld_out <= 1'b1;
			hc(1);
			rd_vld_out <= 1'b0;
		end
		mosi_oe_out <= 1'b0;
		hc(8);
		csb_n_out <= 1'b1;
		hc(16);
	endtask
endmodule

// ### tb/accel_serial_register_interface_tb.sv
// self-checking bench for the serial register interface
`include "asri_map.vh"
module accel_serial_register_interface_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock_in = 1'b0, rst_in = 1'b1, four_r = 1'b0, pat_r = 1'b0;
	logic        acc_valid_in = 1'b0, low_g_in = 1'b0, high_g_in = 1'b0, any_motion_in = 1'b0;
	logic        self_check_ok_in = 1'b0, alert_mode_in = 1'b0;
	logic [9:0]  ax [3] = '{3{10'h000}};
	logic [9:0]  old;
	logic [7:0]  temp_in = 8'h00, low_g_image_in = 8'h01, high_g_image_in = 8'h01, d;
	logic [8:0]  rd;
	logic [17:0] e;
	logic [17:0] q [$];
	logic        rd_vld, sck, csb_n, h_d, h_oe;
	int          n_mismatch = 0, samples_checked = 0;
	wire         sdi_out, sdi_oe_out, sdo_out, sdo_oe_out, zero_acc_out, mems_force_out;
	wire         sleep_out, int_out, alert_out;
	wire [7:0]   low_g_duration_out, high_g_duration_out;
	// shared line: an enabled party drives, else a toggling pattern
	wire         sdi_w = sdi_oe_out ? sdi_out : (h_oe ? h_d : pat_r);
	wire         sdo_w = sdo_oe_out ? sdo_out : pat_r;
	always #5 clock_in = ~clock_in;
	always @(posedge clock_in) pat_r <= ~pat_r;
	asri_core i_asri_core (.clock_in, .rst_in, .sck_in(sck), .csb_n_in(csb_n), .sdi_in(sdi_w),
		.sdi_out, .sdi_oe_out, .sdo_out, .sdo_oe_out, .acc_x_in(ax[0]), .acc_y_in(ax[1]),
		.acc_z_in(ax[2]), .acc_valid_in, .temp_in, .low_g_in, .high_g_in, .any_motion_in,
		.self_check_ok_in, .low_g_image_in, .high_g_image_in, .alert_mode_in, .zero_acc_out,
		.mems_force_out, .sleep_out, .int_out, .alert_out, .low_g_duration_out,
		.high_g_duration_out);
	asri_host i_asri_host (.clock_in, .line_in(four_r ? sdo_w : sdi_w),
		.dev_oe_in(four_r ? sdo_oe_out : sdi_oe_out), .sck_out(sck), .csb_n_out(csb_n),
		.mosi_out(h_d), .mosi_oe_out(h_oe), .rd_out(rd), .rd_vld_out(rd_vld));
	task chk(input string n, input logic [8:0] s, input logic [8:0] x);
		samples_checked++;
		if (s !== x) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", n, x, s);
		end
	endtask
	task close_out();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task hc(input int n);
		repeat (n) @(posedge clock_in);
	endtask
	// note: mask and expected value, bit 8 is the device output enable
	task ex(input logic [8:0] m, input logic [8:0] x);
		q.push_back({m, x & m});
	endtask
	task rdb(input logic [6:0] a, input int n);
		i_asri_host.xfer(1'b1, a, 8'h00, n, 8, four_r);
	endtask
	task wr(input logic [6:0] a, input logic [7:0] v);
		i_asri_host.xfer(1'b0, a, v, 1, 8, four_r);
	endtask
	task sample();
		acc_valid_in <= 1'b1;
		hc(1);
		acc_valid_in <= 1'b0;
		hc(3);
	endtask
	// monitor: each returned byte against the oldest note
	always @(posedge clock_in)
		if (rd_vld === 1'b1) begin
			e = q.pop_front();
			chk("read byte", rd & e[17:9], e[8:0]);
		end
	// hang guard, well beyond the expected run
	initial begin
		hc(40000);
		n_mismatch++;
		close_out();
	end
	initial begin
		void'($urandom(8189));
		hc(10);
		rst_in <= 1'b0;
		low_g_image_in <= 8'h01 | 8'($urandom);
		high_g_image_in <= 8'h01 | 8'($urandom);
		hc(5);
		ex(9'h107, {6'h20, `ASRI_PART_CODE});
		ex(9'h1ff, {1'b1, `ASRI_REV_CODE});
		rdb(`ASRI_ADDR_PART_IDENT, 2);
		// fresh sample read as one burst through temperature
		temp_in <= 8'($urandom);
		for (int k = 0; k < 3; k++)
			ax[k] <= 10'($urandom);
		sample();
		for (int k = 0; k < 3; k++) begin
			ex(9'h1c1, {1'b1, ax[k][1:0], 6'h01});
			ex(9'h1ff, {1'b1, ax[k][9:2]});
		end
		ex(9'h1ff, {1'b1, temp_in});
		// read starts promptly after the fresh sample
		rdb(`ASRI_ADDR_X_LOW, 7);
		// low read clears the flag and freezes the high byte
		old = ax[0];
		ex(9'h101, 9'h100);
		rdb(`ASRI_ADDR_X_LOW, 1);
		ax[0] <= ~old;
		sample();
		ex(9'h1ff, {1'b1, old[9:2]});
		rdb(`ASRI_ADDR_X_HIGH, 1);
		// a cut-short write must not land
		d = 8'($urandom);
		wr(`ASRI_ADDR_SCRATCH_ONE, d);
		i_asri_host.xfer(1'b0, `ASRI_ADDR_SCRATCH_ONE, ~d, 1, 4, four_r);
		ex(9'h1ff, {1'b1, d});
		rdb(`ASRI_ADDR_SCRATCH_ONE, 1);
		// command bits: sleep, then only a wake-up while asleep
		wr(`ASRI_ADDR_COMMAND, 8'h01);
		chk("sleep", {8'h00, sleep_out}, 9'h001);
		wr(`ASRI_ADDR_COMMAND, 8'h00);
		ex(9'h1ff, {1'b1, d});
		rdb(`ASRI_ADDR_SCRATCH_ONE, 1);
		wr(`ASRI_ADDR_COMMAND, 8'h08);
		chk("zero path", {8'h00, zero_acc_out}, 9'h001);
		wr(`ASRI_ADDR_COMMAND, 8'h00);
		self_check_ok_in <= 1'b1;
		wr(`ASRI_ADDR_COMMAND, 8'h04);
		chk("self check", {8'h00, mems_force_out}, 9'h001);
		hc(300);
		ex(9'h104, 9'h100);
		rdb(`ASRI_ADDR_COMMAND, 1);
		ex(9'h180, 9'h180);
		rdb(`ASRI_ADDR_CONDITION, 1);
		// held flag survives the criterion, cleared by interrupt clear
		high_g_in <= 1'b1;
		hc(4);
		high_g_in <= 1'b0;
		hc(4);
		ex(9'h10d, 9'h104);
		rdb(`ASRI_ADDR_CONDITION, 1);
		wr(`ASRI_ADDR_COMMAND, 8'h40);
		chk("int", {8'h00, int_out}, 9'h000);
		ex(9'h104, 9'h100);
		rdb(`ASRI_ADDR_CONDITION, 1);
		// alert entered on motion, left on threshold with durations restored
		alert_mode_in <= 1'b1;
		any_motion_in <= 1'b1;
		hc(4);
		any_motion_in <= 1'b0;
		chk("alert", {8'h00, alert_out}, 9'h001);
		high_g_in <= 1'b1;
		hc(4);
		chk("alert end", {8'h00, alert_out}, 9'h000);
		chk("low dur", {1'b0, low_g_duration_out}, {1'b0, low_g_image_in});
		chk("high dur", {1'b0, high_g_duration_out}, {1'b0, high_g_image_in});
		high_g_in <= 1'b0;
		alert_mode_in <= 1'b0;
		ex(9'h100, 9'h000);
		rdb(7'h20, 1);
		// four-wire, then reinitialise from sleep back to three-wire
		wr(`ASRI_ADDR_SETUP, 8'h80);
		four_r <= 1'b1;
		hc(1);
		ex(9'h1ff, {1'b1, `ASRI_REV_CODE});
		rdb(`ASRI_ADDR_REVISION, 1);
		wr(`ASRI_ADDR_COMMAND, 8'h01);
		wr(`ASRI_ADDR_COMMAND, 8'h02);
		four_r <= 1'b0;
		hc(1000);
		chk("sleep after reinit", {8'h00, sleep_out}, 9'h000);
		ex(9'h1ff, {1'b1, `ASRI_REV_CODE});
		rdb(`ASRI_ADDR_REVISION, 1);
		close_out();
	end
endmodule
